// ### hdl/drp_byte_bank.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Byte register bank with per-byte write masks
module drp_byte_bank #(
    parameter int unsigned                 NUM   = 13,
    parameter int unsigned                 W     = 8,
    parameter int unsigned                 IDX_W = 4,
    parameter logic [NUM-1:0][W-1:0]       WMASK = '1,
    parameter logic [W-1:0]                RVAL  = '0
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      wr_en,
    input  wire logic [IDX_W-1:0]          wr_idx,
    input  wire logic [W-1:0]              wr_data,
    output logic      [NUM-1:0][W-1:0]     bytes_q
);

    // ========================================================
    // Elaboration checks
    if (NUM < 1 || NUM > (1 << IDX_W)) begin : g_chk_num
        $error("drp_byte_bank: NUM does not fit the index width");
    end
    if (W < 1) begin : g_chk_w
        $error("drp_byte_bank: W must be at least one");
    end

    // ========================================================
    // One register per entry; reserved bits never store
    for (genvar i = 0; i < NUM; i++) begin : g_byte
        localparam logic [IDX_W-1:0] MY_IDX = IDX_W'(i);
        always_ff @(posedge clk) begin
            if (rst) begin
                bytes_q[i] <= RVAL & WMASK[i];
            end else if (wr_en && wr_idx == MY_IDX) begin
                bytes_q[i] <= wr_data & WMASK[i];
            end
        end
    end

endmodule // drp_byte_bank
`default_nettype wire

// ### hdl/drp_pkg.sv
`default_nettype none
// ============================================================
// Shared constants and types for the reference A loop profile
package drp_pkg;

    // ========================================================
    // Register bus geometry
    localparam int unsigned DRP_ADDR_W   = 12;
    localparam int unsigned DRP_DATA_W   = 8;
    localparam int unsigned DRP_NUM_REGS = 13;
    localparam int unsigned DRP_IDX_W    = 4;

    // ========================================================
    // Register offsets
    localparam logic [11:0] DRP_OFS_PRIO_EN    = 12'h440;
    localparam logic [11:0] DRP_OFS_BW_LOW     = 12'h441;
    localparam logic [11:0] DRP_OFS_BW_MID     = 12'h442;
    localparam logic [11:0] DRP_OFS_FILT_BWTOP = 12'h443;
    localparam logic [11:0] DRP_OFS_NDIV_LOW   = 12'h444;
    localparam logic [11:0] DRP_OFS_NDIV_MID   = 12'h445;
    localparam logic [11:0] DRP_OFS_NDIV_TOP   = 12'h446;
    localparam logic [11:0] DRP_OFS_NUM_LOW    = 12'h447;
    localparam logic [11:0] DRP_OFS_NUM_MID    = 12'h448;
    localparam logic [11:0] DRP_OFS_NUM_HIGH   = 12'h449;
    localparam logic [11:0] DRP_OFS_MOD_LOW    = 12'h44a;
    localparam logic [11:0] DRP_OFS_MOD_MID    = 12'h44b;
    localparam logic [11:0] DRP_OFS_MOD_HIGH   = 12'h44c;
    // Read-only status and derived ratio bytes
    localparam logic [11:0] DRP_OFS_STATUS     = 12'h4f0;
    localparam logic [11:0] DRP_OFS_RATIO_LOW  = 12'h4f1;
    localparam logic [11:0] DRP_OFS_RATIO_MID  = 12'h4f2;
    localparam logic [11:0] DRP_OFS_RATIO_TOP  = 12'h4f3;

    // ========================================================
    // Bank indices (offset minus first offset)
    localparam logic [3:0] DRP_IDX_PRIO_EN    = 4'h0;
    localparam logic [3:0] DRP_IDX_BW_LOW     = 4'h1;
    localparam logic [3:0] DRP_IDX_BW_MID     = 4'h2;
    localparam logic [3:0] DRP_IDX_FILT_BWTOP = 4'h3;
    localparam logic [3:0] DRP_IDX_NDIV_LOW   = 4'h4;
    localparam logic [3:0] DRP_IDX_NDIV_MID   = 4'h5;
    localparam logic [3:0] DRP_IDX_NDIV_TOP   = 4'h6;
    localparam logic [3:0] DRP_IDX_NUM_LOW    = 4'h7;
    localparam logic [3:0] DRP_IDX_NUM_MID    = 4'h8;
    localparam logic [3:0] DRP_IDX_NUM_HIGH   = 4'h9;
    localparam logic [3:0] DRP_IDX_MOD_LOW    = 4'ha;
    localparam logic [3:0] DRP_IDX_MOD_MID    = 4'hb;
    localparam logic [3:0] DRP_IDX_MOD_HIGH   = 4'hc;

    // ========================================================
    // Field positions
    localparam int unsigned DRP_ENABLE_BIT = 0;
    localparam int unsigned DRP_PRIO_LSB   = 1;
    localparam int unsigned DRP_BW16_BIT   = 0;
    localparam int unsigned DRP_FILT_BIT   = 1;
    localparam int unsigned DRP_ST_FRAC    = 0;
    localparam int unsigned DRP_ST_BWZERO  = 1;
    localparam int unsigned DRP_ST_HPMADV  = 2;
    localparam int unsigned DRP_ST_LOWBW   = 3;

    // ========================================================
    // Reset value and writable bits per register (index 0 lowest)
    localparam logic [7:0] DRP_RESET_VAL = 8'h00;
    localparam logic [12:0][7:0] DRP_WMASK = {
        8'hff, 8'hff, 8'hff,            // Modulus high, mid, low
        8'hff, 8'hff, 8'hff,            // Numerator high, mid, low
        8'h03, 8'hff, 8'hff,            // Integer divider top, mid, low
        8'h03, 8'hff, 8'hff,            // Filter/bw top, bw mid, bw low
        8'h07                           // Priority and enable
    };

    // ========================================================
    // Advisory bandwidth limits, factor counts in 0.1 Hz steps
    localparam int unsigned DRP_BW_STEPS_PER_HZ = 10;
    localparam int unsigned DRP_HPM_ADVISE_HZ   = 2000;
    localparam int unsigned DRP_LOW_BW_HZ       = 50;
    localparam logic [16:0] DRP_HPM_ADVISE_CNT =
        17'(DRP_HPM_ADVISE_HZ * DRP_BW_STEPS_PER_HZ);
    localparam logic [16:0] DRP_LOW_BW_CNT =
        17'(DRP_LOW_BW_HZ * DRP_BW_STEPS_PER_HZ);

    // ========================================================
    // Types
    typedef enum logic [1:0] {
        DRP_PRIO_L0 = 2'h0,
        DRP_PRIO_L1 = 2'h1,
        DRP_PRIO_L2 = 2'h2,
        DRP_PRIO_L3 = 2'h3
    } drp_prio_t;

    typedef struct packed {
        drp_prio_t   prio_lvl;
        logic        enable;
        logic [16:0] bw_scale;
        logic        high_pm;
        logic [17:0] int_div;
        logic [18:0] div_ratio;
        logic [23:0] frac_num;
        logic [23:0] frac_mod;
        logic        frac_active;
    } drp_profile_t;

endpackage : drp_pkg
`default_nettype wire

// ### hdl/drp_ref_a_profile_regs.sv
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - A two-bit priority for reference input A resets to 00, the highest level, with 01..11 lower levels 1..3.
// R2 - One enable bit lets the first digital loop lock to reference input A; clear at reset excludes it.
// R3 - The 17-bit bandwidth factor in 0.1 Hz steps joins two bytes and bit 16 of the third register, resetting to zero.
// R4 - Software keeps the loop bandwidth below one fiftieth of the phase detector frequency.
// R5 - Software avoids bandwidths under 50 Hz when the system clock comes from a crystal.
// R6 - The filter select bit picks the normal 70 degree margin filter when clear and the high margin filter when set.
// R7 - Software selects the high margin filter for bandwidths above 2 kHz.
// R8 - The 18-bit integer feedback divider spans three registers and stores the ratio minus one.
// R9 - The integer divider registers reset to an all-zero combined value.
// R10 - The 24-bit fractional numerator spans three byte registers, low byte first, each resetting to zero.
// R11 - The 24-bit fractional modulus spans three byte registers, low byte first, each resetting to zero.
// R12 - A zero modulus disables and bypasses the fractional divider, leaving integer division only.
// R13 - Effective division is the stored integer plus one, plus numerator over modulus when the modulus is nonzero.
module drp_ref_a_profile_regs
    import drp_pkg::*;
(
    input  wire logic                  CLK,
    input  wire logic                  RST,
    input  wire logic [DRP_ADDR_W-1:0] ADDR,
    input  wire logic [DRP_DATA_W-1:0] WDATA,
    input  wire logic                  WR,
    input  wire logic                  RD,
    output logic      [DRP_DATA_W-1:0] RDATA,
    output drp_profile_t               PROFILE
);

    // ========================================================
    // Address decode
    logic                                  bank_hit;
    logic [DRP_IDX_W-1:0]                  bank_idx;
    logic [DRP_ADDR_W-1:0]                 addr_rel;

    // Offset relative to the first register of the bank
    assign addr_rel = ADDR - DRP_OFS_PRIO_EN;
    assign bank_hit = (ADDR >= DRP_OFS_PRIO_EN) && (ADDR <= DRP_OFS_MOD_HIGH);
    assign bank_idx = addr_rel[DRP_IDX_W-1:0];

    // ========================================================
    // Register storage
    logic [DRP_NUM_REGS-1:0][DRP_DATA_W-1:0] bytes_q;

    // Reserved bits are masked at write and reset to zero
    drp_byte_bank #(
        .NUM   (DRP_NUM_REGS),
        .W     (DRP_DATA_W),
        .IDX_W (DRP_IDX_W),
        .WMASK (DRP_WMASK),
        .RVAL  (DRP_RESET_VAL)
    ) u_bank (
        .clk     (CLK),
        .rst     (RST),                             // R9
        .wr_en   (WR && bank_hit),
        .wr_idx  (bank_idx),
        .wr_data (WDATA),
        .bytes_q (bytes_q)
    );

    // ========================================================
    // Field extraction
    drp_prio_t                             prio_f;
    logic                                  enable_f;
    logic [16:0]                           bw_f;
    logic                                  high_pm_f;
    logic [17:0]                           ndiv_f;
    logic [23:0]                           num_f;
    logic [23:0]                           mod_f;

    // Priority level and enable bit of the first register
    assign prio_f   = drp_prio_t'(bytes_q[DRP_IDX_PRIO_EN][DRP_PRIO_LSB +: 2]); // R1
    assign enable_f = bytes_q[DRP_IDX_PRIO_EN][DRP_ENABLE_BIT];              // R2

    // Bandwidth factor: two full bytes plus bit 16
    assign bw_f = {bytes_q[DRP_IDX_FILT_BWTOP][DRP_BW16_BIT],
                   bytes_q[DRP_IDX_BW_MID],
                   bytes_q[DRP_IDX_BW_LOW]};                                 // R3

    // Clear picks the normal margin filter, set the high margin one
    assign high_pm_f = bytes_q[DRP_IDX_FILT_BWTOP][DRP_FILT_BIT];            // R6

    // Integer divider, stored ratio minus one
    assign ndiv_f = {bytes_q[DRP_IDX_NDIV_TOP][1:0],
                     bytes_q[DRP_IDX_NDIV_MID],
                     bytes_q[DRP_IDX_NDIV_LOW]};                             // R8

    // Fractional numerator and modulus, low byte first
    assign num_f = {bytes_q[DRP_IDX_NUM_HIGH],
                    bytes_q[DRP_IDX_NUM_MID],
                    bytes_q[DRP_IDX_NUM_LOW]};                               // R10
    assign mod_f = {bytes_q[DRP_IDX_MOD_HIGH],
                    bytes_q[DRP_IDX_MOD_MID],
                    bytes_q[DRP_IDX_MOD_LOW]};                               // R11

    // ========================================================
    // Derived divider terms
    logic [18:0]                           ratio_f;
    logic                                  frac_active_f;
    logic [23:0]                           frac_num_eff;

    // Division ratio is the stored value plus one
    assign ratio_f = 19'({1'b0, ndiv_f} + 19'h0_0001);                      // R13

    // A zero modulus turns the fractional part off
    assign frac_active_f = |mod_f;                                           // R12

    // Bypassed fraction hands the loop a zero numerator
    assign frac_num_eff = frac_active_f ? num_f : 24'h00_0000;              // R12

    // ========================================================
    // Advisory checks on the programmed bandwidth
    logic                                  bw_zero_f;
    logic                                  hpm_advise_f;
    logic                                  low_bw_f;

    // Zero factor leaves the loop undefined
    assign bw_zero_f = (bw_f == 17'h0_0000);

    // Above 2 kHz with the normal margin filter still chosen
    assign hpm_advise_f = (bw_f > DRP_HPM_ADVISE_CNT) && !high_pm_f;        // R7

    // Nonzero bandwidth below 50 Hz
    assign low_bw_f = !bw_zero_f && (bw_f < DRP_LOW_BW_CNT);                 // R5

    // ========================================================
    // Profile register towards the loop engine
    always_ff @(posedge CLK) begin
        if (RST) begin
            PROFILE.prio_lvl    <= DRP_PRIO_L0;                              // R1
            PROFILE.enable      <= 1'b0;                                     // R2
            PROFILE.bw_scale    <= 17'h0_0000;                               // R3
            PROFILE.high_pm     <= 1'b0;                                     // R6
            PROFILE.int_div     <= 18'h0_0000;                               // R9
            PROFILE.div_ratio   <= 19'h0_0001;                               // R13
            PROFILE.frac_num    <= 24'h00_0000;                              // R10
            PROFILE.frac_mod    <= 24'h00_0000;                              // R11
            PROFILE.frac_active <= 1'b0;                                     // R12
        end else begin
            PROFILE.prio_lvl    <= prio_f;
            PROFILE.enable      <= enable_f;
            PROFILE.bw_scale    <= bw_f;
            PROFILE.high_pm     <= high_pm_f;
            PROFILE.int_div     <= ndiv_f;
            PROFILE.div_ratio   <= ratio_f;
            PROFILE.frac_num    <= frac_num_eff;
            PROFILE.frac_mod    <= mod_f;
            PROFILE.frac_active <= frac_active_f;
        end
    end

    // ========================================================
    // Status byte, read only
    logic [DRP_DATA_W-1:0]                 status_nxt;

    // Packs derived flags; unused bits read zero
    always_comb begin
        status_nxt                = 8'h00;
        status_nxt[DRP_ST_FRAC]   = frac_active_f;
        status_nxt[DRP_ST_BWZERO] = bw_zero_f;
        status_nxt[DRP_ST_HPMADV] = hpm_advise_f;
        status_nxt[DRP_ST_LOWBW]  = low_bw_f;
    end

    // ========================================================
    // Read path, data one cycle after the strobe
    logic [DRP_DATA_W-1:0]                 rdata_nxt;

    // Bank bytes, status and ratio; anything else reads zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (bank_hit) begin
            rdata_nxt = bytes_q[bank_idx];
        end else begin
            unique case (ADDR)
                DRP_OFS_STATUS:    rdata_nxt = status_nxt;
                DRP_OFS_RATIO_LOW: rdata_nxt = ratio_f[7:0];
                DRP_OFS_RATIO_MID: rdata_nxt = ratio_f[15:8];
                DRP_OFS_RATIO_TOP: rdata_nxt = {5'h00, ratio_f[18:16]};
                default:           rdata_nxt = 8'h00;
            endcase
        end
    end

    // Holds read data for exactly the cycle after a read strobe
    always_ff @(posedge CLK) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            RDATA <= rdata_nxt;
        end else begin
            RDATA <= 8'h00;
        end
    end

endmodule // drp_ref_a_profile_regs
`default_nettype wire

// ### verification/drp_ref_a_profile_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port-level checks of the reference A profile bank
module drp_ref_a_profile_assertions
    import drp_pkg::*;
(
    input  wire logic                  CLK,
    input  wire logic                  RST,
    input  wire logic [DRP_ADDR_W-1:0] ADDR,
    input  wire logic [DRP_DATA_W-1:0] WDATA,
    input  wire logic                  WR,
    input  wire logic                  RD,
    input  wire logic [DRP_DATA_W-1:0] RDATA,
    input  wire drp_profile_t          PROFILE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // ========================================================
    // Written bytes reach the profile two edges after the strobe
    prio_write_a: assert property (
        WR && ADDR == 12'h440 |-> ##2
        {PROFILE.prio_lvl, PROFILE.enable} == 3'($past(WDATA, 2)))
        else $error("priority or enable does not follow write");
    bw_low_a: assert property (
        WR && ADDR == 12'h441 |-> ##2
        PROFILE.bw_scale[7:0] == $past(WDATA, 2))
        else $error("bandwidth low byte does not follow write");
    filt_top_a: assert property (
        WR && ADDR == 12'h443 |-> ##2
        {PROFILE.high_pm, PROFILE.bw_scale[16]} == 2'($past(WDATA, 2)))
        else $error("filter select or bandwidth bit 16 wrong");
    ndiv_top_a: assert property (
        WR && ADDR == 12'h446 |-> ##2
        PROFILE.int_div[17:16] == 2'($past(WDATA, 2)))
        else $error("divider top bits do not follow write");
    mod_high_a: assert property (
        WR && ADDR == 12'h44c |-> ##2
        PROFILE.frac_mod[23:16] == $past(WDATA, 2))
        else $error("modulus high byte does not follow write");

    // ========================================================
    // Derived fields and idle behaviour
    ratio_plus_a: assert property (
        PROFILE.div_ratio == {1'b0, PROFILE.int_div} + 19'h0_0001)
        else $error("division ratio is not stored value plus one");
    frac_bypass_a: assert property (
        PROFILE.frac_active == (PROFILE.frac_mod != 24'h00_0000) &&
        (PROFILE.frac_active || PROFILE.frac_num == 24'h00_0000))
        else $error("fraction bypass wrong for modulus");
    profile_hold_a: assert property (
        !WR ##1 !WR |=> $stable(PROFILE))
        else $error("profile changed without a write");
    rdata_idle_a: assert property (
        !$past(RD) |-> RDATA == 8'h00)
        else $error("read data not zero outside read answer");

    // Main scenarios reached
    cov_prio_c: cover property (WR && ADDR == 12'h440);
    cov_frac_c: cover property ($rose(PROFILE.frac_active));
    cov_read_c: cover property (RD ##1 RDATA != 8'h00);
endmodule // drp_ref_a_profile_assertions

bind drp_ref_a_profile_regs drp_ref_a_profile_assertions chk_u (
    .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .PROFILE(PROFILE));
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
// ============================================================
// Self-checking bench for the reference A profile bank
module tb
    import drp_pkg::*;
;
    logic                  CLK, RST, WR, RD;
    logic [DRP_ADDR_W-1:0] ADDR;
    logic [DRP_DATA_W-1:0] WDATA, RDATA, v;
    drp_profile_t          PROFILE;
    int                    n_errors, n_checks;

    drp_ref_a_profile_regs dut_u (.CLK(CLK), .RST(RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .PROFILE(PROFILE));

    // Clock of 100 ns period
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    // ========================================================
    // Bus cycles, entered just after a rising edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK);
        WR    <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD   <= 1'b0;
        // Read data stand in this cycle; take them at its closing edge
        @(posedge CLK);
        v = RDATA;
        `CHK(v, e)
    endtask

    // ========================================================
    // Scenarios
    task automatic t_reset();
        for (int i = 0; i < 13; i++) begin
            rdc(12'h440 + 12'(i), 8'h00);
        end
        `CHK(PROFILE.div_ratio, 19'h0_0001)
        `CHK(PROFILE.bw_scale, 17'h0_0000)
        `CHK({PROFILE.prio_lvl, PROFILE.enable, PROFILE.high_pm}, 4'h0)
        rdc(12'h4f0, 8'h02);
        rdc(12'h4f1, 8'h01);
        $display("test reset done");
    endtask
    task automatic t_prio();
        for (int p = 0; p < 4; p++) begin
            wr(12'h440, 8'(p * 2 + 1) | 8'hf8);
            rdc(12'h440, 8'(p * 2 + 1));
            `CHK(PROFILE.prio_lvl, drp_prio_t'(p))
            `CHK(PROFILE.enable, 1'b1)
        end
        wr(12'h440, 8'h06);
        wr(12'h43f, 8'hff);
        rdc(12'h440, 8'h06);
        `CHK(PROFILE.enable, 1'b0)
        $display("test priority done");
    endtask
    task automatic t_bw();
        wr(12'h441, 8'h34);
        rdc(12'h4f0, 8'h08);
        wr(12'h442, 8'h12);
        wr(12'h443, 8'h01);
        rdc(12'h4f0, 8'h04);
        wr(12'h443, 8'hff);
        rdc(12'h443, 8'h03);
        `CHK(PROFILE.bw_scale, 17'h1_1234)
        `CHK(PROFILE.high_pm, 1'b1)
        rdc(12'h4f0, 8'h00);
        wr(12'h443, 8'h00);
        rdc(12'h442, 8'h12);
        `CHK(PROFILE.high_pm, 1'b0)
        `CHK(PROFILE.bw_scale, 17'h0_1234)
        $display("test bandwidth done");
    endtask
    task automatic t_div();
        wr(12'h444, 8'hff);
        wr(12'h445, 8'hff);
        wr(12'h446, 8'hff);
        rdc(12'h446, 8'h03);
        `CHK(PROFILE.int_div, 18'h3_ffff)
        `CHK(PROFILE.div_ratio, 19'h4_0000)
        rdc(12'h4f1, 8'h00);
        rdc(12'h4f3, 8'h04);
        $display("test divider done");
    endtask
    task automatic t_frac();
        wr(12'h447, 8'h56);
        wr(12'h448, 8'h34);
        wr(12'h449, 8'h12);
        rdc(12'h449, 8'h12);
        `CHK(PROFILE.frac_active, 1'b0)
        `CHK(PROFILE.frac_num, 24'h00_0000)
        wr(12'h44c, 8'h01);
        wr(12'h4f0, 8'hff);
        rdc(12'h44c, 8'h01);
        rdc(12'h4ff, 8'h00);
        `CHK(PROFILE.frac_mod, 24'h01_0000)
        `CHK(PROFILE.frac_active, 1'b1)
        `CHK(PROFILE.frac_num, 24'h12_3456)
        rdc(12'h4f0, 8'h01);
        wr(12'h44c, 8'h00);
        rdc(12'h44c, 8'h00);
        `CHK(PROFILE.frac_active, 1'b0)
        `CHK(PROFILE.frac_num, 24'h00_0000)
        $display("test fraction done");
    endtask

    // ========================================================
    // Verdict and hang guard
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge CLK);
        n_errors++;
        conclude();
    end

    // Main sequence with a second reset in mid-run
    initial begin
        {RST, WR, RD, ADDR, WDATA} = '0;
        RST      = 1'b1;
        n_errors = 0;
        n_checks = 0;
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        t_reset();
        t_prio();
        t_bw();
        t_div();
        t_frac();
        RST <= 1'b1;
        @(posedge CLK);
        RST <= 1'b0;
        t_reset();
        conclude();
    end
endmodule // tb
`default_nettype wire
